// [epx_pkg.sv]
package epx_pkg;
  // ----------------------------------------
  // clocking
  // ----------------------------------------
  localparam int MCLK_HZ = 25_000_000;
  localparam int MCLK_PER_PIX = 2;
  // ----------------------------------------
  // line timing, in pixel clocks
  // ----------------------------------------
  localparam int LINE_SYNC_LEN = 2;
  localparam int LINE_LEAD_BLANK_LEN = 7;
  localparam int LINE_ACTIVE_LEN = 300;
  localparam int LINE_TRAIL_LEN = 71;
  localparam int LINE_LEN = LINE_SYNC_LEN + LINE_LEAD_BLANK_LEN + LINE_ACTIVE_LEN
    + LINE_TRAIL_LEN;
  localparam int ROW_CLOCK_START_OFFSET = 10;
  localparam int ROW_ON_LENGTH = 256;
  localparam int H_ACT_FIRST = LINE_SYNC_LEN + LINE_LEAD_BLANK_LEN;
  localparam int H_ACT_END = H_ACT_FIRST + LINE_ACTIVE_LEN;
  localparam int H_LATCH = H_ACT_END + 1;
  // ----------------------------------------
  // frame timing, in lines
  // ----------------------------------------
  localparam int FRAME_SYNC_LINES = 1;
  localparam int FRAME_LEAD_BLANK_LINES = 4;
  localparam int FRAME_ACTIVE_LINES = 1034;
  localparam int FRAME_TRAIL_LINES = 14;
  localparam int FRAME_LINES = FRAME_SYNC_LINES + FRAME_LEAD_BLANK_LINES
    + FRAME_ACTIVE_LINES + FRAME_TRAIL_LINES;
  localparam int V_ROW_START = FRAME_SYNC_LINES;
  localparam int V_ACT_FIRST = FRAME_SYNC_LINES + FRAME_LEAD_BLANK_LINES;
  localparam int V_ACT_END = V_ACT_FIRST + FRAME_ACTIVE_LINES;
  // ----------------------------------------
  // supply sequencing and data buffer
  // ----------------------------------------
  localparam int STEP_TIME_US = 1000;
  localparam int DISCH_TIME_MS = 500;
  localparam int STEP_CYCLES = STEP_TIME_US * (MCLK_HZ / 1_000_000);
  localparam int DISCH_CYCLES = DISCH_TIME_MS * (MCLK_HZ / 1000);
  localparam int RAIL_VDD = 0;
  localparam int RAIL_NEG_COLUMN_RAIL = 1;
  localparam int RAIL_VEE = 2;
  localparam int RAIL_POS_COLUMN_RAIL = 3;
  localparam int RAIL_VGH = 4;
  localparam int RAIL_VCOM = 5;
  localparam int RAIL_N = 6;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;

  typedef enum logic [2:0] {
    PWR_OFF = 3'b000,
    PWR_UP = 3'b001,
    PWR_ON = 3'b010,
    PWR_STOP = 3'b011,
    PWR_DOWN = 3'b100,
    PWR_DISCH = 3'b101
  } epx_pwr_state_t;

  typedef struct packed {
    logic clk;
    logic start_n;
    logic latch;
    logic oe;
    logic [FIFO_W-1:0] data;
  } epx_src_t;

  typedef struct packed {
    logic clk;
    logic start;
    logic mode;
  } epx_gate_t;
endpackage

// [epx_panel_ctrl.sv]
// Operation
// R1: pixel clock carries 8 pixels per cycle for the 2400x1034 panel
// R2: line is sync 2, lead blank 7, data 300, trail 71 pixel clocks
// R3: row clock starts 10 pixel clocks into the line, high 256
// R4: frame is 1 sync, 4 lead, 1034 active, 14 trail lines; max 75 Hz
// R5: row-on window follows the row clock; line clock stays internal
// R6: fixed option: row start equals lead blank, length data plus half
// R7: row output mode low in sync line; row start in first lead line
// R8: clock, start, latch, enable and row pins map one to one
// R9: source rails up: logic, negative, positive, then common
// R10: gate rails up: logic, negative gate, then positive gate
// R11: logic off 0.5 s after negative gate off and discharged
// R12: latch strobe pulses after each line's data is shifted
// R13: rails go down in reverse order after drive stops
// R14: line is 380 pixel clocks; counters wrap together at frame end
`timescale 1ns/1ps
`default_nettype none
module epx_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;

  assign in_ready = (wp_q - rp_q) != FULL;
  assign out_valid = wp_q != rp_q;
  assign out_data = mem[rp_q[AW-1:0]];

  always_ff @(posedge mclk)
  begin
    if (in_valid && in_ready)
      mem[wp_q[AW-1:0]] <= in_data;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wp_q <= wp_q + 1'b1;
      if (out_valid && out_ready)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule // epx_fifo

module epx_panel_ctrl
  import epx_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES,
  parameter int DISCH_CYC = DISCH_CYCLES,
  parameter bit FIXED_ROW_TIMING = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // user side
  input wire logic power_req,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [FIFO_W-1:0] pix_data,
  input wire logic underrun_clr,
  output logic underrun,
  output logic power_good,
  // panel drive pins
  output var epx_src_t src_pins,
  output var epx_gate_t gate_pins,
  output logic row_on_window,
  // supply enables and discharge sense
  output logic [RAIL_N-1:0] rail_en,
  input wire logic neg_row_rail_discharged
);
  // ----------------------------------------
  // constants at signal width
  // ----------------------------------------
  localparam logic [8:0] H_LAST = 9'(LINE_LEN - 1);
  localparam logic [10:0] V_LAST = 11'(FRAME_LINES - 1);
  localparam logic [9:0] RS2 = FIXED_ROW_TIMING ? 10'(MCLK_PER_PIX * LINE_LEAD_BLANK_LEN)
    : 10'(MCLK_PER_PIX * ROW_CLOCK_START_OFFSET);
  localparam logic [9:0] RL2 = FIXED_ROW_TIMING ? 10'(MCLK_PER_PIX * LINE_ACTIVE_LEN + 1)
    : 10'(MCLK_PER_PIX * ROW_ON_LENGTH);
  localparam logic [23:0] STEP_LAST = 24'(STEP_CYC - 1);
  localparam logic [23:0] DISCH_LAST = 24'(DISCH_CYC - 1);

  epx_pwr_state_t st_q;
  logic [23:0] timer_q;
  logic [2:0] step_q;
  logic [RAIL_N-1:0] rails_q;
  logic [2:0] sns_q;
  logic dischg_q;
  logic phase_q;
  logic [8:0] h_q;
  logic [10:0] v_q;
  logic [8:0] h_d;
  logic [10:0] v_d;
  logic run;
  logic tick;
  logic frame_end;
  logic act_line_d;
  logic act_px_d;
  logic fifo_valid;
  logic [FIFO_W-1:0] fifo_data;
  logic pop;
  logic [9:0] pos;
  logic row_q;
  logic underrun_q;
  logic pgood_q;
  epx_src_t src_q;
  epx_gate_t gate_q;

  // ----------------------------------------
  // data buffer
  // ----------------------------------------
  epx_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(pix_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------
  // discharge sense synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sns_q <= 3'h0;
      dischg_q <= 1'b0;
    end
    else
    begin
      sns_q <= {sns_q[1:0], neg_row_rail_discharged};
      if (sns_q[1] == sns_q[2])
        dischg_q <= sns_q[2];
    end
  end

  // ----------------------------------------
  // supply sequencer
  // ----------------------------------------
  // one interleaved order satisfies both the source and the gate chains
  function automatic int up_bit(input logic [2:0] s);
    case (s)
      3'h0: up_bit = RAIL_VDD;
      3'h1: up_bit = RAIL_NEG_COLUMN_RAIL;
      3'h2: up_bit = RAIL_VEE;
      3'h3: up_bit = RAIL_POS_COLUMN_RAIL;
      3'h4: up_bit = RAIL_VGH;
      default: up_bit = RAIL_VCOM;
    endcase
  endfunction

  function automatic int dn_bit(input logic [2:0] s);
    case (s)
      3'h0: dn_bit = RAIL_VCOM;
      3'h1: dn_bit = RAIL_VGH;
      3'h2: dn_bit = RAIL_POS_COLUMN_RAIL;
      3'h3: dn_bit = RAIL_NEG_COLUMN_RAIL;
      default: dn_bit = RAIL_VEE;
    endcase
  endfunction

  assign run = (st_q == PWR_ON) || (st_q == PWR_STOP);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= PWR_OFF;
      timer_q <= 24'h0;
      step_q <= 3'h0;
    end
    else
    begin
      case (st_q)
        PWR_OFF:
        begin
          timer_q <= 24'h0;
          step_q <= 3'h0;
          if (power_req)
            st_q <= PWR_UP;
        end
        PWR_UP:
        begin
          timer_q <= (timer_q == STEP_LAST) ? 24'h0 : timer_q + 24'h1;
          if (timer_q == STEP_LAST)
          begin
            step_q <= step_q + 3'h1;
            if (step_q == 3'h5)
              st_q <= PWR_ON;
          end
        end
        PWR_ON:
          if (!power_req)
            st_q <= PWR_STOP;
        PWR_STOP:
        begin
          timer_q <= 24'h0;
          step_q <= 3'h0;
          if (frame_end)
            st_q <= PWR_DOWN; // R13
        end
        PWR_DOWN:
        begin
          timer_q <= (timer_q == STEP_LAST) ? 24'h0 : timer_q + 24'h1;
          if (timer_q == STEP_LAST)
          begin
            step_q <= step_q + 3'h1;
            if (step_q == 3'h4)
              st_q <= PWR_DISCH;
          end
        end
        PWR_DISCH:
        begin
          if (timer_q != DISCH_LAST)
            timer_q <= timer_q + 24'h1;
          else if (dischg_q)
            st_q <= PWR_OFF; // R11
        end
        default:
          st_q <= PWR_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rails_q <= '0;
    else if (st_q == PWR_UP && timer_q == STEP_LAST)
      rails_q[up_bit(step_q)] <= 1'b1; // R9 R10
    else if (st_q == PWR_DOWN && timer_q == STEP_LAST)
      rails_q[dn_bit(step_q)] <= 1'b0; // R13
    else if (st_q == PWR_DISCH && timer_q == DISCH_LAST && dischg_q)
      rails_q[RAIL_VDD] <= 1'b0; // R11
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pgood_q <= 1'b0;
    else
      pgood_q <= st_q == PWR_ON;
  end

  // ----------------------------------------
  // line and frame counters
  // ----------------------------------------
  // pixel clock is mclk/2, so the frame runs below 75 Hz by construction
  assign tick = phase_q;
  assign h_d = (h_q == H_LAST) ? 9'h0 : h_q + 9'h1; // R14
  assign v_d = (h_q != H_LAST) ? v_q : (v_q == V_LAST) ? 11'h0 : v_q + 11'h1; // R4
  assign frame_end = tick && h_q == H_LAST && v_q == V_LAST;
  assign act_line_d = v_d >= 11'(V_ACT_FIRST) && v_d < 11'(V_ACT_END);
  assign act_px_d = h_d >= 9'(H_ACT_FIRST) && h_d < 9'(H_ACT_END); // R2
  assign pop = run && tick && act_line_d && act_px_d && fifo_valid; // R1
  assign pos = {h_q, phase_q};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= 1'b0;
      h_q <= 9'h0;
      v_q <= 11'h0;
    end
    else if (!run)
    begin
      phase_q <= 1'b0;
      h_q <= 9'h0;
      v_q <= 11'h0;
    end
    else
    begin
      phase_q <= ~phase_q;
      if (tick)
      begin
        h_q <= h_d; // R14
        v_q <= v_d;
      end
    end
  end

  // ----------------------------------------
  // column drive
  // ----------------------------------------
  // data and strobes change with the clock low, giving half a period of setup
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      src_q <= '{clk: 1'b0, start_n: 1'b1, latch: 1'b0, oe: 1'b0, data: '0};
    else if (!run)
      src_q <= '{clk: 1'b0, start_n: 1'b1, latch: 1'b0, oe: 1'b0, data: '0};
    else if (tick)
    begin
      src_q.clk <= 1'b0;
      src_q.data <= pop ? fifo_data : '0; // R1
      src_q.start_n <= !(act_line_d && h_d == 9'(H_ACT_FIRST)); // R2
      src_q.latch <= act_line_d && h_d == 9'(H_LATCH); // R12
      src_q.oe <= act_line_d;
    end
    else
      // clock the pixel now on the bus, not the one that follows it
      src_q.clk <= src_q.oe && h_q >= 9'(H_ACT_FIRST) && h_q < 9'(H_ACT_END); // R8
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      underrun_q <= 1'b0;
    else if (run && tick && act_line_d && act_px_d && !fifo_valid)
      underrun_q <= 1'b1;
    else if (underrun_clr)
      underrun_q <= 1'b0;
  end

  // ----------------------------------------
  // row drive
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      row_q <= 1'b0;
      gate_q <= '0;
    end
    else if (!run)
    begin
      row_q <= 1'b0;
      gate_q <= '0;
    end
    else
    begin
      row_q <= pos >= RS2 && pos < RS2 + RL2; // R3 R6
      gate_q.clk <= pos >= RS2 && pos < RS2 + RL2; // R8
      gate_q.start <= v_q == 11'(V_ROW_START); // R7
      gate_q.mode <= v_q >= 11'(FRAME_SYNC_LINES); // R7
    end
  end

  assign src_pins = src_q; // R8
  assign gate_pins = gate_q;
  assign row_on_window = row_q; // R5
  assign rail_en = rails_q;
  assign underrun = underrun_q;
  assign power_good = pgood_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [9:0] row_len_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      row_len_q <= 10'h0;
    else
      row_len_q <= row_q ? row_len_q + 10'h1 : 10'h0;
  end

  sequence s_line_wrap;
    run && tick && h_q == H_LAST;
  endsequence

  sequence s_col_start;
    $fell(src_q.start_n) ##1 src_q.clk;
  endsequence

  chk_row_len: assert property (@(posedge mclk) disable iff (!rst_n) // R3
    $fell(row_q) |-> $past(row_len_q) == RL2 - 10'h1)
    else $error("row clock high time wrong");
  chk_row_start: assert property (@(posedge mclk) disable iff (!rst_n) // R6
    $rose(row_q) |-> $past(pos) == RS2)
    else $error("row clock starts at wrong position");
  chk_window_follow: assert property (@(posedge mclk) disable iff (!rst_n) // R5
    row_on_window == gate_pins.clk)
    else $error("row window not following row clock");
  chk_mode_sync: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    run && $past(run) && $past(v_q) == 11'h0 |-> !gate_q.mode)
    else $error("row output mode high during sync line");
  chk_row_strobe: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    $rose(gate_q.start) |-> $past(v_q) == 11'(V_ROW_START))
    else $error("row start outside first lead line");
  chk_line_wrap: assert property (@(posedge mclk) disable iff (!rst_n) // R14
    s_line_wrap |=> !run || (h_q == 9'h0 && v_q == $past(v_d)))
    else $error("line counter wrap wrong");
  chk_col_start: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    $fell(src_q.start_n) |-> h_q == 9'(H_ACT_FIRST) ##0 s_col_start)
    else $error("column start misplaced");
  chk_col_clock: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    src_q.clk |-> src_q.oe && h_q >= 9'(H_ACT_FIRST) && h_q < 9'(H_ACT_END))
    else $error("column clock outside active pixels");
  chk_latch_pos: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    $rose(src_q.latch) |-> h_q == 9'(H_LATCH) && src_q.oe)
    else $error("latch strobe misplaced");
  chk_src_order: assert property (@(posedge mclk) disable iff (!rst_n) // R9
    $rose(rails_q[RAIL_VCOM]) |-> &rails_q)
    else $error("common rail before source rails");
  chk_gate_order: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    $rose(rails_q[RAIL_VGH]) |-> rails_q[RAIL_VEE] && rails_q[RAIL_VDD])
    else $error("positive gate rail before negative");
  chk_down_order: assert property (@(posedge mclk) disable iff (!rst_n) // R13
    $fell(rails_q[RAIL_VEE]) |-> !rails_q[RAIL_NEG_COLUMN_RAIL] && !rails_q[RAIL_VGH] && !run)
    else $error("negative gate rail off out of order");
  chk_logic_off: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    $fell(rails_q[RAIL_VDD]) |-> $past(timer_q) == DISCH_LAST && $past(dischg_q)
      && !rails_q[RAIL_VEE])
    else $error("logic rail removed too early");
endmodule // epx_panel_ctrl
`default_nettype wire

// [epx_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module epx_panel_model
  import epx_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // drive pins
  input wire epx_src_t src_pins,
  input wire epx_gate_t gate_pins,
  input wire logic row_on_window,
  // supplies
  input wire logic [RAIL_N-1:0] rail_en,
  output logic neg_row_rail_discharged,
  // tallies
  output int errs,
  output int checks
);
  // rail that must already be up before each rail rises
  localparam logic [RAIL_N-1:0] NEED [RAIL_N] = '{6'h00, 6'h01, 6'h01, 6'h02, 6'h04, 6'h08};
  logic [RAIL_N-1:0] rail_q;
  logic rclk_q, start_q, latch_q, sclk_q;
  int hi_n, per_n, pix_n, rows_n, dis_n;

  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errs++;
      $display("[FAIL] t=%0t panel got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // supplies, row and column timing
  // ----------------------------------------
  // rail discharge is slow on purpose so the sense input is not high at once
  assign neg_row_rail_discharged = (dis_n == 10);
  initial
  begin
    errs = 0;
    checks = 0;
  end
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {rail_q, rclk_q, start_q, latch_q, sclk_q} <= '0;
      {hi_n, per_n, pix_n, rows_n, dis_n} <= '0;
    end
    else
    begin
      rail_q <= rail_en;
      rclk_q <= gate_pins.clk;
      start_q <= gate_pins.start;
      latch_q <= src_pins.latch;
      sclk_q <= src_pins.clk;
      for (int k = 0; k < RAIL_N; k++)
        if (rail_en[k] && !rail_q[k])
          expect_eq(rail_q & NEED[k], NEED[k]);
      dis_n <= rail_en[RAIL_VEE] ? 0 : (dis_n < 10 ? dis_n + 1 : dis_n);
      expect_eq(row_on_window, gate_pins.clk);
      if (gate_pins.clk && !rclk_q)
      begin
        expect_eq(rail_q, 6'h3F);
        if (rows_n == 0)
          expect_eq(gate_pins.mode, 1'b0);
        if (per_n > 0)
          expect_eq(per_n, LINE_LEN * MCLK_PER_PIX);
        per_n <= 1;
        rows_n <= rows_n + 1;
      end
      else if (per_n > 0)
        per_n <= per_n + 1;
      hi_n <= gate_pins.clk ? hi_n + 1 : 0;
      if (!gate_pins.clk && rclk_q)
        expect_eq(hi_n, ROW_ON_LENGTH * MCLK_PER_PIX);
      if (gate_pins.start && !start_q)
      begin
        expect_eq(gate_pins.mode, 1'b1);
        expect_eq(rows_n, 1);
      end
      if (src_pins.clk && !sclk_q)
      begin
        pix_n <= pix_n + 1;
        expect_eq(src_pins.oe, 1'b1);
      end
      if (src_pins.latch && !latch_q)
      begin
        if (pix_n > 0)
          expect_eq(pix_n, LINE_ACTIVE_LEN);
        pix_n <= 0;
      end
    end
  end
endmodule // epx_panel_model
`default_nettype wire

// [epx_panel_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
module epx_panel_ctrl_test
  import epx_pkg::*;
;
  localparam int STEP = 8;
  localparam int LIMIT = 10000;
  logic mclk, rst_n, power_req, pix_valid, pix_ready, underrun_clr, underrun, power_good;
  logic row_on_window, neg_row_rail_discharged, took, sclk_q;
  logic [FIFO_W-1:0] pix_data, d;
  logic [RAIL_N-1:0] rail_en;
  epx_src_t src_pins;
  epx_gate_t gate_pins;
  logic [FIFO_W-1:0] expq[$];
  int fails = 0;
  int checked = 0;
  int m_errs, m_checks, n, sent, cyc, pix_seen;

  epx_panel_ctrl #(.STEP_CYC(STEP), .DISCH_CYC(20), .FIXED_ROW_TIMING(1'b0)) epx_panel_ctrl_i (
    .mclk(mclk), .rst_n(rst_n), .power_req(power_req), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_data(pix_data), .underrun_clr(underrun_clr),
    .underrun(underrun), .power_good(power_good), .src_pins(src_pins),
    .gate_pins(gate_pins), .row_on_window(row_on_window), .rail_en(rail_en),
    .neg_row_rail_discharged(neg_row_rail_discharged));
  epx_panel_model epx_panel_model_i (
    .mclk(mclk), .rst_n(rst_n), .src_pins(src_pins), .gate_pins(gate_pins),
    .row_on_window(row_on_window), .rail_en(rail_en),
    .neg_row_rail_discharged(neg_row_rail_discharged), .errs(m_errs), .checks(m_checks));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // offer d once; ready is sampled mid-cycle so the edge's own update cannot race it
  task automatic push();
    pix_valid = 1'b1;
    pix_data = d;
    @(negedge mclk);
    took = pix_ready;
    tick(1);
    if (took)
    begin
      expq.push_back(d);
      d = 8'($urandom);
    end
  endtask

  task automatic conclude();
    $display("checked=%0d fails=%0d", checked + m_checks, fails + m_errs);
    if (fails + m_errs == 0 && checked + m_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fails++;
      conclude();
    end
  end

  // column data watcher: an empty queue means the design must send zero
  always @(negedge mclk)
  begin
    sclk_q <= src_pins.clk;
    if (rst_n && src_pins.clk && !sclk_q)
    begin
      chk(src_pins.data, expq.size() > 0 ? expq.pop_front() : 8'h00);
      pix_seen++;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {rst_n, power_req, pix_valid, underrun_clr} = 4'h0;
    pix_data = 8'h00;
    void'($urandom(61794));
    d = 8'($urandom);
    tick(6);
    rst_n = 1'b1;
    tick(1);
    chk(rail_en, 6'h00);
    chk(src_pins.start_n, 1'b1);
    chk(pix_ready, 1'b1);
    chk(power_good, 1'b0);
    $display("test reset done");
    sent = 0;
    do
    begin
      push();
      sent += took;
    end while (took);
    chk(sent, FIFO_D);
    $display("test fill done");
    power_req = 1'b1;
    n = 0;
    do
    begin
      tick(1);
      n++;
      // a drop of the request while rails ramp must be ignored
      power_req = !(n inside {[3:5]});
    end while (!rail_en[RAIL_VCOM] && n < 1000);
    chk(n >= 6 * STEP && n <= 6 * STEP + 2, 1'b1);
    chk(rail_en, 6'h3F);
    tick(3);
    chk(power_good, 1'b1);
    $display("test power up done");
    while (sent < 2 * LINE_ACTIVE_LEN)
    begin
      push();
      sent += took;
    end
    pix_valid = 1'b0;
    chk(underrun, 1'b0);
    while (pix_seen < 3 * LINE_ACTIVE_LEN)
      tick(1);
    tick(4);
    chk(underrun, 1'b1);
    underrun_clr = 1'b1;
    tick(1);
    underrun_clr = 1'b0;
    tick(1);
    chk(underrun, 1'b0);
    $display("test stream done");
    rst_n = 1'b0;
    tick(1);
    chk(rail_en, 6'h00);
    chk(gate_pins.clk, 1'b0);
    chk(src_pins.start_n, 1'b1);
    rst_n = 1'b1;
    tick(2);
    chk(rail_en, 6'h00);
    chk(power_good, 1'b0);
    $display("test second reset done");
    conclude();
  end
endmodule // epx_panel_ctrl_test
`default_nettype wire
